// ==== hdl/l2pmmu_defs.svh ====
`ifndef L2PMMU_DEFS_SVH
`define L2PMMU_DEFS_SVH

// internal i/o offsets of the translation registers
`define L2P_OFS_UPPER_COMMON_BASE 8'h38
`define L2P_OFS_BANK_BASE 8'h39
`define L2P_OFS_AREA_BOUNDARIES 8'h3a
// field positions inside area_boundaries
`define L2P_UCS_MSB 7
`define L2P_UCS_LSB 4
`define L2P_BKS_MSB 3
`define L2P_BKS_LSB 0
// reset values
`define L2P_RST_AREA_BOUNDARIES 8'hf0
`define L2P_RST_BASE 8'h00
// page size in address bits (4 KB pages)
`define L2P_PAGE_BITS 12

`endif

// ==== hdl/l2pmmu_pkg.sv ====
package l2pmmu_pkg;
  // kind of bus cycle issued by the cpu core
  typedef enum logic [1:0] {
    L2P_CYC_IDLE,
    L2P_CYC_MEM,
    L2P_CYC_IO,
    L2P_CYC_DMA
  } l2p_cyc_e;

  // logical request from the core
  typedef struct packed {
    l2p_cyc_e cyc;
    logic [15:0] addr;
    logic [19:0] dma_addr;
  } l2p_req_s;

  // internal i/o register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } l2p_io_s;

  // physical side of the bus
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [19:0] addr;
  } l2p_phys_s;

  typedef enum logic [1:0] {
    L2P_AREA_LOW,
    L2P_AREA_BANK,
    L2P_AREA_HIGH
  } l2p_area_e;
endpackage

// ==== hdl/l2pmmu_xlate.sv ====
`timescale 1ns/100ps
`include "l2pmmu_defs.svh"

// combinational area classifier and base adder
module l2pmmu_xlate (
  input wire logic [15:0] laddr_in, // logical address
  input wire logic [7:0] bounds_in, // area boundaries register
  input wire logic [7:0] ucbase_in, // upper common base
  input wire logic [7:0] bkbase_in, // bank base
  output l2pmmu_pkg::l2p_area_e area_out, // classified area
  output logic [19:0] paddr_out // physical address
);
  import l2pmmu_pkg::*;

  logic [3:0] page;
  logic [7:0] base;
  logic [7:0] frame;

  // compare page against the boundaries, pick base, add
  always_comb begin
    page = laddr_in[15:12];
    if (page >= bounds_in[`L2P_UCS_MSB:`L2P_UCS_LSB]) begin
      area_out = L2P_AREA_HIGH;
      base = ucbase_in;
    end else if (page >= bounds_in[`L2P_BKS_MSB:`L2P_BKS_LSB]) begin
      area_out = L2P_AREA_BANK;
      base = bkbase_in;
    end else begin
      area_out = L2P_AREA_LOW;
      base = 8'h00;
    end
    // 8-bit frame wraps inside 1 MB
    frame = base + {4'h0, page};
    paddr_out = {frame, laddr_in[11:0]};
  end
endmodule

// ==== hdl/l2pmmu_top.sv ====
// Contract
// - memory cycles map a 16-bit logical address onto a 20-bit physical address.
// - logical space is split into lower common, bank and upper common on 4 KB pages.
// - the upper nibble of area_boundaries is the first page of upper common and ends bank.
// - the lower nibble of area_boundaries is the first page of bank and ends lower common.
// - the area's base is added to logical bits 15:12 to form the physical address.
// - upper common accesses use upper_common_base.
// - lower common accesses use a fixed base of zero.
// - only cpu memory cycles (L2P_CYC_MEM) are translated.
// - i/o cycles pass the 16-bit address with bits 19:16 low.
// - dma cycles drive the dma channel's 20-bit address directly.
// - reset gives upper start all ones, bank start zero and both bases zero.
// - a register write affects translation from the very next bus cycle.
// - translation adds no bus cycles.
`timescale 1ns/100ps
`include "l2pmmu_defs.svh"

module l2pmmu_top (
  input wire logic clk_sys_in, // cpu clock
  input wire logic sys_rst_in, // async reset, high
  input wire logic clk_en_in, // freezes all state when low
  input l2pmmu_pkg::l2p_req_s req_in, // logical cycle from core
  input l2pmmu_pkg::l2p_io_s io_in, // internal i/o access
  output l2pmmu_pkg::l2p_phys_s phys_out, // registered physical cycle
  output logic [7:0] rdata_out, // registered read data
  output logic rvalid_out // read data strobe
);
  import l2pmmu_pkg::*;

  ////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0] bounds;
    logic [7:0] ucbase;
    logic [7:0] bkbase;
    l2p_phys_s phys;
    logic [7:0] rdata;
    logic rvalid;
  } l2p_state_s;

  l2p_state_s st_r;
  l2p_state_s st_nxt;
  l2p_area_e area;
  logic [19:0] mem_paddr;
  logic io_hit;

  ////////////////////////////////////////////////////////////////
  // translation uses the live registers, so a write is seen next cycle
  l2pmmu_xlate l2pmmu_xlate_inst (
    .laddr_in(req_in.addr),
    .bounds_in(st_r.bounds),
    .ucbase_in(st_r.ucbase),
    .bkbase_in(st_r.bkbase),
    .area_out(area),
    .paddr_out(mem_paddr)
  );

  // on-chip registers only answer with a zero high byte
  assign io_hit = (io_in.addr[15:8] == 8'h00);

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    // register writes
    // writes to unmapped low offsets are dropped without trace
    if (io_in.wr && io_hit) begin
      case (io_in.addr[7:0])
        `L2P_OFS_UPPER_COMMON_BASE: begin
          st_nxt.ucbase = io_in.wdata;
        end
        `L2P_OFS_BANK_BASE: begin
          st_nxt.bkbase = io_in.wdata;
        end
        `L2P_OFS_AREA_BOUNDARIES: begin
          st_nxt.bounds = io_in.wdata;
        end
        default: begin
        end
      endcase
    end
    // register reads; other offsets return zero
    // a read in the cycle of a write still returns the old value
    if (io_in.rd && io_hit) begin
      st_nxt.rvalid = 1'b1;
      case (io_in.addr[7:0])
        `L2P_OFS_UPPER_COMMON_BASE: begin
          st_nxt.rdata = st_r.ucbase;
        end
        `L2P_OFS_BANK_BASE: begin
          st_nxt.rdata = st_r.bkbase;
        end
        `L2P_OFS_AREA_BOUNDARIES: begin
          st_nxt.rdata = st_r.bounds;
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end
    // physical cycle, one register stage, no extra bus cycles
    st_nxt.phys.valid = (req_in.cyc != L2P_CYC_IDLE);
    st_nxt.phys.is_io = 1'b0;
    case (req_in.cyc)
      L2P_CYC_MEM: begin
        st_nxt.phys.addr = mem_paddr;
      end
      L2P_CYC_IO: begin
        st_nxt.phys.is_io = 1'b1;
        st_nxt.phys.addr = {4'h0, req_in.addr};
      end
      L2P_CYC_DMA: begin
        st_nxt.phys.addr = req_in.dma_addr;
      end
      // idle: hold the last address rather than drive a guess
      default: begin
        st_nxt.phys.addr = st_r.phys.addr;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
      st_r.bounds <= `L2P_RST_AREA_BOUNDARIES;
      st_r.ucbase <= `L2P_RST_BASE;
      st_r.bkbase <= `L2P_RST_BASE;
    end else if (clk_en_in) begin
      st_r <= st_nxt;
    end
  end

  assign phys_out = st_r.phys;
  assign rdata_out = st_r.rdata;
  assign rvalid_out = st_r.rvalid;

  ////////////////////////////////////////////////////////////////
  // checks
  sequence s_bounds_wr;
    io_in.wr && io_hit && io_in.addr[7:0] == `L2P_OFS_AREA_BOUNDARIES && clk_en_in;
  endsequence

  chk_reset_map: assert property (@(posedge clk_sys_in)
    $fell(sys_rst_in) |-> st_r.bounds == 8'hf0 && st_r.ucbase == 8'h00
      && st_r.bkbase == 8'h00)
    else $error("reset values of translation registers wrong");

  chk_io_high_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc == L2P_CYC_IO |=> phys_out.addr == {4'h0, $past(req_in.addr)}
      && phys_out.is_io)
    else $error("io cycle address not passed through");

  chk_dma_bypass: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc == L2P_CYC_DMA |=> phys_out.addr == $past(req_in.dma_addr))
    else $error("dma address not passed through");

  chk_low_area_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc == L2P_CYC_MEM && area == L2P_AREA_LOW
      |=> phys_out.addr[19:16] == 4'h0 && phys_out.addr[15:0] == $past(req_in.addr))
    else $error("lower common not based at zero");

  chk_high_area_base: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc == L2P_CYC_MEM
      && req_in.addr[15:12] >= st_r.bounds[7:4]
      |=> phys_out.addr[19:12] == 8'($past(st_r.ucbase) + $past(req_in.addr[15:12])))
    else $error("upper common base not applied");

  chk_bank_area_base: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc == L2P_CYC_MEM && area == L2P_AREA_BANK
      |=> phys_out.addr[19:12] == 8'($past(st_r.bkbase) + $past(req_in.addr[15:12])))
    else $error("bank base not applied");

  chk_write_next: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_bounds_wr |=> st_r.bounds == $past(io_in.wdata))
    else $error("boundary write not effective next cycle");

  chk_no_stall: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc != L2P_CYC_IDLE |=> phys_out.valid)
    else $error("bus cycle dropped or delayed");

  chk_high_byte: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && io_in.rd && io_in.addr[15:8] != 8'h00 |=> !rvalid_out)
    else $error("register answered with nonzero high byte");

  ////////////////////////////////////////////////////////////////
  // checks on reset, freeze and the register port
  sequence s_ucbase_wr;
    io_in.wr && io_hit && io_in.addr[7:0] == `L2P_OFS_UPPER_COMMON_BASE && clk_en_in;
  endsequence

  sequence s_bkbase_wr;
    io_in.wr && io_hit && io_in.addr[7:0] == `L2P_OFS_BANK_BASE && clk_en_in;
  endsequence

  sequence s_ucbase_rd;
    io_in.rd && io_hit && io_in.addr[7:0] == `L2P_OFS_UPPER_COMMON_BASE && clk_en_in;
  endsequence

  sequence s_bkbase_rd;
    io_in.rd && io_hit && io_in.addr[7:0] == `L2P_OFS_BANK_BASE && clk_en_in;
  endsequence

  sequence s_bounds_rd;
    io_in.rd && io_hit && io_in.addr[7:0] == `L2P_OFS_AREA_BOUNDARIES && clk_en_in;
  endsequence

  // outputs leave reset quiet, so the bus sees no stray cycle
  chk_reset_phys: assert property (@(posedge clk_sys_in)
    $fell(sys_rst_in) |-> phys_out == '0 && !rvalid_out && rdata_out == 8'h00)
    else $error("outputs not quiet after reset");

  // a low enable holds every bit; a request standing meanwhile is lost, not queued
  chk_freeze_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !clk_en_in |=> $stable(st_r))
    else $error("state moved while enable low");

  // base writes steer the very next bus cycle
  chk_ucbase_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_ucbase_wr |=> st_r.ucbase == $past(io_in.wdata))
    else $error("upper base write not effective next cycle");

  chk_bkbase_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_bkbase_wr |=> st_r.bkbase == $past(io_in.wdata))
    else $error("bank base write not effective next cycle");

  // an ignored write must leave the map alone, or a stray i/o cycle remaps memory
  chk_ignored_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && io_in.wr && !io_hit
      |=> $stable(st_r.bounds) && $stable(st_r.ucbase) && $stable(st_r.bkbase))
    else $error("register written with nonzero high byte");

  // reads return the value before any write of the same cycle
  chk_read_ucbase: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_ucbase_rd |=> rvalid_out && rdata_out == $past(st_r.ucbase))
    else $error("upper base read back wrong");

  chk_read_bkbase: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_bkbase_rd |=> rvalid_out && rdata_out == $past(st_r.bkbase))
    else $error("bank base read back wrong");

  // both starts come back as one byte, upper start in the high nibble
  chk_read_bounds: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_bounds_rd |=> rvalid_out && rdata_out == $past(st_r.bounds))
    else $error("area boundaries read back wrong");

  // unmapped low offsets still answer, with zero
  chk_unmapped_read: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && io_in.rd && io_hit && !(io_in.addr[7:0] inside {`L2P_OFS_UPPER_COMMON_BASE,
      `L2P_OFS_BANK_BASE, `L2P_OFS_AREA_BOUNDARIES}) |=> rvalid_out && rdata_out == 8'h00)
    else $error("unmapped offset read not zero");

  // rvalid is high only in the cycle after a read
  chk_rvalid_pulse: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && !(io_in.rd && io_hit) |=> !rvalid_out)
    else $error("read strobe longer than one cycle");

  // rdata stays until the next read, so a slow reader still sees it
  chk_rdata_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && !(io_in.rd && io_hit) |=> $stable(rdata_out))
    else $error("read data changed without a read");

  ////////////////////////////////////////////////////////////////
  // checks on the classifier and the physical cycle
  // a memory cycle never shows as i/o on the bus
  chk_mem_not_io: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc == L2P_CYC_MEM |=> phys_out.valid && !phys_out.is_io)
    else $error("memory cycle flagged as io");

  // dma addresses are physical already, never an i/o cycle
  chk_dma_not_io: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc == L2P_CYC_DMA |=> phys_out.valid && !phys_out.is_io)
    else $error("dma cycle flagged as io");

  // idle keeps the last address so the lines do not toggle for nothing
  chk_idle_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc == L2P_CYC_IDLE |=> !phys_out.valid && $stable(phys_out.addr))
    else $error("idle cycle disturbed the bus");

  // upper wins even if software breaks the order of the two starts
  chk_high_span: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc == L2P_CYC_MEM && area == L2P_AREA_HIGH
      |-> req_in.addr[15:12] >= st_r.bounds[`L2P_UCS_MSB:`L2P_UCS_LSB])
    else $error("upper common classified below its start");

  // bank pages run from the bank start up to, not including, the upper start
  chk_bank_span: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc == L2P_CYC_MEM && area == L2P_AREA_BANK
      |-> req_in.addr[15:12] >= st_r.bounds[`L2P_BKS_MSB:`L2P_BKS_LSB]
      && req_in.addr[15:12] < st_r.bounds[`L2P_UCS_MSB:`L2P_UCS_LSB])
    else $error("bank area classified outside its pages");

  // lower common lies below both starts
  chk_low_span: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in && req_in.cyc == L2P_CYC_MEM && area == L2P_AREA_LOW
      |-> req_in.addr[15:12] < st_r.bounds[`L2P_BKS_MSB:`L2P_BKS_LSB]
      && req_in.addr[15:12] < st_r.bounds[`L2P_UCS_MSB:`L2P_UCS_LSB])
    else $error("lower common classified at or above the bank start");
endmodule

// ==== tb/l2pmmu_core.sv ====
`timescale 1ns/100ps

// core-side model, issues one logical cycle per call
module l2pmmu_core (
  input wire logic clk_in, // cpu clock
  output l2pmmu_pkg::l2p_req_s req_out, // logical cycle to the mmu
  output l2pmmu_pkg::l2p_io_s io_out // internal register access
);
  import l2pmmu_pkg::*;

  // idle at time zero so nothing is taken during reset
  initial begin
    req_out = '0;
    io_out = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // called at a rising edge; values stand until the next call
  // bounds are only programmed with upper start not below bank start
  task automatic drive(l2p_cyc_e c, logic [15:0] a, logic [19:0] d, logic wr, logic rd,
                       logic hi, logic [7:0] ofs, logic [7:0] wd);
    req_out <= '{cyc: c, addr: a, dma_addr: d};
    // high byte nonzero only when a refusal is wanted
    io_out <= '{wr: wr, rd: rd, addr: {(hi ? 8'h5a : 8'h00), ofs}, wdata: wd};
  endtask
endmodule

// ==== tb/tb_l2pmmu_top.sv ====
`timescale 1ns/100ps

module tb_l2pmmu_top;
  import l2pmmu_pkg::*;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_en = 1'b1;
  l2p_req_s req;
  l2p_io_s io;
  l2p_phys_s phys, exp_p;
  logic [7:0] rdata, exp_d;
  logic rvalid, exp_v;
  logic [7:0] sh [3];
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  initial forever #5 clk_sys_in = ~clk_sys_in;

  l2pmmu_core l2pmmu_core_inst (.clk_in(clk_sys_in), .req_out(req), .io_out(io));
  // enable is lowered once, by the freeze test
  l2pmmu_top l2pmmu_top_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en), .req_in(req), .io_in(io), .phys_out(phys), .rdata_out(rdata),
    .rvalid_out(rvalid));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // reference translation from the shadow registers
  function automatic logic [19:0] xl(logic [15:0] a);
    logic [7:0] b;
    b = (a[15:12] >= sh[2][7:4]) ? sh[0] : (a[15:12] >= sh[2][3:0]) ? sh[1] : 8'h00;
    return {b + {4'h0, a[15:12]}, a[11:0]};
  endfunction

  // results are one cycle late, so each call checks the previous request
  task automatic step(l2p_cyc_e c, logic [15:0] a, logic [19:0] d, logic wr, logic rd,
                      logic hi, logic [7:0] ofs, logic [7:0] wd);
    logic hit;
    hit = !hi && (ofs inside {8'h38, 8'h39, 8'h3a});
    @(posedge clk_sys_in);
    l2pmmu_core_inst.drive(c, a, d, wr, rd, hi, ofs, wd);
    @(negedge clk_sys_in);
    if (exp_p.valid) check("phys", 32'(phys), 32'(exp_p));
    else check("phys_valid", 32'(phys.valid), 32'(0));
    check("rvalid", 32'(rvalid), 32'(exp_v));
    if (exp_v) check("rdata", 32'(rdata), 32'(exp_d));
    exp_p.valid = (c != L2P_CYC_IDLE);
    if (c != L2P_CYC_IDLE) exp_p.is_io = (c == L2P_CYC_IO);
    if (c == L2P_CYC_MEM) exp_p.addr = xl(a);
    if (c == L2P_CYC_IO) exp_p.addr = {4'h0, a};
    if (c == L2P_CYC_DMA) exp_p.addr = d;
    exp_v = rd && !hi;
    if (rd) exp_d = hit ? sh[ofs - 8'h38] : 8'h00;
    if (wr && hit) sh[ofs - 8'h38] = wd;
  endtask

  // enable low: outputs keep the last result, and the write and dma cycle
  // standing meanwhile are never taken; idle is what it sees on waking
  task automatic freeze(int n);
    @(posedge clk_sys_in);
    clk_en <= 1'b0;
    l2pmmu_core_inst.drive(L2P_CYC_DMA, 16'h0000, 20'h5_5555, 1'b1, 1'b1, 1'b0, 8'h39, 8'h66);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    if (exp_p.valid) check("frozen_phys", 32'(phys), 32'(exp_p));
    check("frozen_rvalid", 32'(rvalid), 32'(exp_v));
    @(posedge clk_sys_in);
    clk_en <= 1'b1;
    l2pmmu_core_inst.drive(L2P_CYC_IDLE, 16'h0000, 20'h0_0000, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    exp_p.valid = 1'b0;
    exp_v = 1'b0;
  endtask

  task automatic mem(logic [15:0] a);
    step(L2P_CYC_MEM, a, 20'h0_0000, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic rw(logic wr, logic rd, logic hi, logic [7:0] ofs, logic [7:0] wd);
    step(L2P_CYC_IDLE, 16'h0000, 20'h0_0000, wr, rd, hi, ofs, wd);
  endtask

  task automatic do_reset(int n);
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    // no request may stand across the release, or it is taken at once
    l2pmmu_core_inst.drive(L2P_CYC_IDLE, 16'h0000, 20'h0_0000, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    repeat (n) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    exp_p = '0;
    exp_v = 1'b0;
    exp_d = 8'h00;
    sh = '{8'h00, 8'h00, 8'hf0};
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // hang guard, well above the ~105 cycles the tests need
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    do_reset(20);
    rw(1'b0, 1'b1, 1'b0, 8'h38, 8'h00);
    rw(1'b0, 1'b1, 1'b0, 8'h39, 8'h00);
    rw(1'b0, 1'b1, 1'b0, 8'h3a, 8'h00);
    rw(1'b0, 1'b1, 1'b0, 8'h3b, 8'h00);
    mem(16'hf123);
    $display("test reset_values done");
    // base write then a memory cycle at once, sum wraps past 8 bits
    rw(1'b1, 1'b0, 1'b0, 8'h38, 8'hf8);
    mem(16'hf000);
    rw(1'b1, 1'b1, 1'b0, 8'h39, 8'h20);
    // every page under several boundary layouts, equal starts included
    foreach (sh[i]) begin
      rw(1'b1, 1'b0, 1'b0, 8'h3a, (i == 0) ? 8'h84 : (i == 1) ? 8'h55 : 8'hf0);
      for (int p = 0; p < 16; p++) mem({p[3:0], 12'habc});
    end
    $display("test regions done");
    step(L2P_CYC_IO, 16'habcd, 20'h0_0000, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    step(L2P_CYC_DMA, 16'h1234, 20'hf_edcb, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    freeze(4);
    rw(1'b0, 1'b1, 1'b0, 8'h39, 8'h00);
    rw(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    mem(16'h5fff);
    $display("test bypass done");
    rw(1'b1, 1'b0, 1'b1, 8'h38, 8'haa);
    rw(1'b0, 1'b1, 1'b1, 8'h38, 8'h00);
    rw(1'b0, 1'b1, 1'b0, 8'h38, 8'h00);
    rw(1'b1, 1'b0, 1'b0, 8'h3b, 8'h77);
    rw(1'b0, 1'b1, 1'b0, 8'h3b, 8'h00);
    $display("test refusal done");
    do_reset(3);
    rw(1'b0, 1'b1, 1'b0, 8'h3a, 8'h00);
    rw(1'b0, 1'b1, 1'b0, 8'h38, 8'h00);
    mem(16'hf123);
    rw(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    $display("test second_reset done");
    end_sim();
  end
endmodule
